// >>> psw_defs.svh
// Function
// RQ1: Status word at D0, carry down to parity.
// RQ2: Bank field maps R0-R7 to four banks.
// RQ3: Parity flag tracks accumulator odd ones.
// RQ4: Aux carry records low nibble carry.
// RQ5: Reset input active high, synchronised internally.
// RQ6: Reset held high two machine cycles minimum.
// RQ7: Reset acts second cycle, repeats while high.
// RQ8: 256-byte data memory, separate 256-byte extended.
// RQ9: 128-byte special register space, separate.
// RQ10: 64K external data and program spaces.
// RQ11: Map bit steers window to mapped registers.
// RQ12: Map bit never cleared by hardware; the core reset and resetn clear it here.
// RQ13: Arithmetic sets carry, overflow; user flags software.
`ifndef PSW_DEFS_SVH
`define PSW_DEFS_SVH
`define ADDR_PSW        8'hD0
`define ADDR_SYSTEM_CONTROL_REGISTER     8'hB1
`define ADDR_ACC        8'hE0
`define ADDR_POWER_CONTROL_SECOND      8'h88
`define ADDR_VR0        8'hFC
`define ADDR_VR1        8'hFD
`define ADDR_VR2        8'hFE
`define PSW_RESET       8'h00
`define SYSTEM_CONTROL_REGISTER_RESET    8'h20
`define SYSTEM_CONTROL_REGISTER_MASK     8'h31
`define ACC_RESET       8'h00
`define POWER_CONTROL_SECOND_RESET     8'h00
`define VR0_VALUE       8'hA5
`define VR1_VALUE       8'h5A
`define VR2_VALUE       8'h3C
`define BIT_CY          7
`define BIT_AC          6
`define BIT_F0          5
`define BIT_RS1         4
`define BIT_RS0         3
`define BIT_OV          2
`define BIT_F1          1
`define BIT_P           0
`define BIT_MAP         4
`define OSC_PER_MC      12
`define RESET_MC_MIN    2
`define IDATA_BYTES     256
`define XDATA_BYTES     256
`define SFR_BYTES       128
`define EXT_SPACE_BYTES 65536
`endif

// >>> psw_pkg.sv
package psw_pkg;
  typedef enum logic [2:0] {
    OP_NONE,
    OP_ADD,
    OP_ADDC,
    OP_SUBB,
    OP_MUL,
    OP_DIV
  } alu_op_t;

  typedef struct packed {
    logic    valid;
    alu_op_t op;
    logic [7:0] a;
    logic [7:0] b;
  } alu_req_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sfr_bus_t;

  typedef struct packed {
    logic [7:0] psw;
    logic [7:0] system_control_register;
    logic [7:0] acc;
    logic [7:0] power_control_second;
    logic [7:0] rdata;
    logic [1:0] rst_sync;
    logic       core_reset;
    logic [3:0] osc_cnt;
    logic       mc_tick;
  } state_t;
endpackage : psw_pkg

// >>> cpu_status_word_and_reset.sv
`include "psw_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module cpu_status_word_and_reset (
  input  wire logic            ref_clk,
  input  wire logic            resetn,
  input  wire logic            reset_pin,
  input  wire psw_pkg::sfr_bus_t bus,
  input  wire psw_pkg::alu_req_t alu,
  output var  logic [7:0]      rdata,
  output var  logic [7:0]      program_status_word,
  output var  logic [7:0]      bank_base,
  output var  logic            sfr_map_select,
  output var  logic            core_reset,
  output var  logic            machine_cycle
);
  import psw_pkg::*;

  state_t s_reg;
  state_t s_next;

  // ****************************************************************
  // Arithmetic flag computation
  // ****************************************************************
  logic [8:0]  sum9;
  logic [4:0]  sum5;
  logic [15:0] prod;
  logic [7:0]  res;
  logic        cy_n;
  logic        ac_n;
  logic        ov_n;
  logic        flags_upd;
  logic        ac_upd;
  logic        cin;

  always_comb begin
    cin       = (alu.op == OP_ADDC || alu.op == OP_SUBB) ? s_reg.psw[`BIT_CY] : 1'b0;
    sum9      = 9'h000;
    sum5      = 5'h00;
    prod      = 16'h0000;
    res       = s_reg.acc;
    cy_n      = s_reg.psw[`BIT_CY];
    ac_n      = s_reg.psw[`BIT_AC];
    ov_n      = s_reg.psw[`BIT_OV];
    flags_upd = 1'b0;
    ac_upd    = 1'b0;
    if (alu.valid) begin
      unique case (alu.op)
        OP_NONE: begin
          res = s_reg.acc;
        end
        OP_ADD, OP_ADDC: begin
          sum9      = {1'b0, alu.a} + {1'b0, alu.b} + {8'h00, cin};
          sum5      = {1'b0, alu.a[3:0]} + {1'b0, alu.b[3:0]} + {4'h0, cin};
          res       = sum9[7:0];
          cy_n      = sum9[8]; // [RQ13]
          ac_n      = sum5[4]; // [RQ4]
          ov_n      = (alu.a[7] == alu.b[7]) && (res[7] != alu.a[7]); // [RQ13]
          flags_upd = 1'b1;
          ac_upd    = 1'b1;
        end
        OP_SUBB: begin
          sum9      = {1'b0, alu.a} - {1'b0, alu.b} - {8'h00, cin};
          sum5      = {1'b0, alu.a[3:0]} - {1'b0, alu.b[3:0]} - {4'h0, cin};
          res       = sum9[7:0];
          cy_n      = sum9[8]; // [RQ13]
          ac_n      = sum5[4]; // [RQ4]
          ov_n      = (alu.a[7] != alu.b[7]) && (res[7] != alu.a[7]); // [RQ13]
          flags_upd = 1'b1;
          ac_upd    = 1'b1;
        end
        OP_MUL: begin
          prod      = {8'h00, alu.a} * {8'h00, alu.b};
          res       = prod[7:0];
          cy_n      = 1'b0; // [RQ13]
          ov_n      = (prod[15:8] != 8'h00); // [RQ13]
          flags_upd = 1'b1;
        end
        OP_DIV: begin
          // A zero divisor leaves the quotient undefined; the accumulator takes the dividend.
          res       = (alu.b == 8'h00) ? alu.a : alu.a / alu.b;
          cy_n      = 1'b0; // [RQ13]
          ov_n      = (alu.b == 8'h00); // [RQ13]
          flags_upd = 1'b1;
        end
        default: begin
          res = s_reg.acc;
        end
      endcase
    end
  end

  // ****************************************************************
  // Register file and reset sequencing
  // ****************************************************************
  logic       sel_std;
  logic       sel_map;
  logic [7:0] rd_val;
  logic [7:0] psw_w;

  always_comb begin
    s_next = s_reg;
    // One machine cycle lasts twelve clocks, the clock standing in for the oscillator.
    s_next.mc_tick = 1'b0;
    if (s_reg.osc_cnt == 4'(`OSC_PER_MC - 1)) begin
      s_next.osc_cnt = 4'h0;
      s_next.mc_tick = 1'b1;
    end else begin
      s_next.osc_cnt = s_reg.osc_cnt + 4'h1;
    end
    // Sampled once per machine cycle; the core reset asserts in the second high cycle
    // and repeats every cycle while the pin stays high. [RQ5] [RQ7]
    if (s_reg.mc_tick) begin
      s_next.rst_sync   = {s_reg.rst_sync[0], reset_pin}; // [RQ5]
      s_next.core_reset = s_next.rst_sync[1] & s_next.rst_sync[0]; // [RQ7]
    end

    sel_std = 1'b0;
    sel_map = 1'b0;
    if (bus.addr[7]) begin // [RQ9]
      sel_map = s_reg.system_control_register[`BIT_MAP]; // [RQ11]
      sel_std = ~s_reg.system_control_register[`BIT_MAP]; // [RQ11]
    end

    psw_w = s_reg.psw;
    if (alu.valid) begin
      s_next.acc = res;
    end
    if (flags_upd) begin
      psw_w[`BIT_CY] = cy_n;
      psw_w[`BIT_OV] = ov_n;
    end
    if (ac_upd) begin
      psw_w[`BIT_AC] = ac_n;
    end

    if (bus.wr && sel_std) begin
      unique case (bus.addr)
        `ADDR_PSW: psw_w = bus.wdata; // [RQ1] [RQ13]
        `ADDR_ACC: s_next.acc = bus.wdata;
        `ADDR_SYSTEM_CONTROL_REGISTER: s_next.system_control_register = bus.wdata & `SYSTEM_CONTROL_REGISTER_MASK; // [RQ12]
        default: begin
        end
      endcase
    end
    if (bus.wr && sel_map && bus.addr == `ADDR_POWER_CONTROL_SECOND) begin
      s_next.power_control_second = bus.wdata; // [RQ11]
    end
    // System control sits in both windows so software can always leave mapped mode.
    if (bus.wr && sel_map && bus.addr == `ADDR_SYSTEM_CONTROL_REGISTER) begin
      s_next.system_control_register = bus.wdata & `SYSTEM_CONTROL_REGISTER_MASK; // [RQ12]
    end

    psw_w[`BIT_P] = ^s_next.acc; // [RQ3]
    s_next.psw = psw_w;

    rd_val = 8'h00;
    if (sel_std) begin
      unique case (bus.addr)
        `ADDR_PSW: rd_val = s_reg.psw; // [RQ1]
        `ADDR_ACC: rd_val = s_reg.acc;
        `ADDR_SYSTEM_CONTROL_REGISTER: rd_val = s_reg.system_control_register;
        default: rd_val = 8'h00;
      endcase
    end else if (sel_map) begin
      unique case (bus.addr)
        `ADDR_POWER_CONTROL_SECOND: rd_val = s_reg.power_control_second; // [RQ11]
        `ADDR_VR0: rd_val = `VR0_VALUE;
        `ADDR_VR1: rd_val = `VR1_VALUE;
        `ADDR_VR2: rd_val = `VR2_VALUE;
        `ADDR_SYSTEM_CONTROL_REGISTER: rd_val = s_reg.system_control_register;
        default: rd_val = 8'h00;
      endcase
    end
    s_next.rdata = bus.rd ? rd_val : 8'h00;

    // The core reset returns the registers it owns, but not the sequencer itself.
    if (s_reg.core_reset) begin // [RQ7]
      s_next.psw    = `PSW_RESET;
      s_next.acc    = `ACC_RESET;
      s_next.system_control_register = `SYSTEM_CONTROL_REGISTER_RESET;
      s_next.power_control_second  = `POWER_CONTROL_SECOND_RESET;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      s_reg.psw        <= `PSW_RESET;
      s_reg.system_control_register     <= `SYSTEM_CONTROL_REGISTER_RESET;
      s_reg.acc        <= `ACC_RESET;
      s_reg.power_control_second      <= `POWER_CONTROL_SECOND_RESET;
      s_reg.rdata      <= 8'h00;
      s_reg.rst_sync   <= 2'b00;
      s_reg.core_reset <= 1'b0;
      s_reg.osc_cnt    <= 4'h0;
      s_reg.mc_tick    <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Bank base is the flag field times eight, a flop copy of the word. [RQ2]
  logic [7:0] bank_base_reg;
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      bank_base_reg <= 8'h00;
    end else begin
      bank_base_reg <= {3'b000, s_next.psw[`BIT_RS1:`BIT_RS0], 3'b000}; // [RQ2] [RQ8]
    end
  end

  assign rdata               = s_reg.rdata;
  assign program_status_word = s_reg.psw;
  assign bank_base           = bank_base_reg;
  assign sfr_map_select      = s_reg.system_control_register[`BIT_MAP];
  assign core_reset          = s_reg.core_reset;
  assign machine_cycle       = s_reg.mc_tick;
  // Address widths of the memory spaces ride on the defines; the external
  // 64K spaces are outside this block. [RQ10]
endmodule : cpu_status_word_and_reset
`default_nettype wire

// >>> cpu_status_word_and_reset_sva.sv
`timescale 1ns/1ps
`default_nettype none
module status_word_checker (
  input wire logic              ref_clk,
  input wire logic              resetn,
  input wire logic              reset_pin,
  input wire psw_pkg::sfr_bus_t bus,
  input wire psw_pkg::alu_req_t alu,
  input wire logic [7:0]        rdata,
  input wire logic [7:0]        program_status_word,
  input wire logic [7:0]        bank_base,
  input wire logic              sfr_map_select,
  input wire logic              core_reset,
  input wire logic              machine_cycle
);
  import psw_pkg::*;
  logic [8:0] sum_w;
  logic [4:0] low_w;
  logic       add_w;
  assign sum_w = {1'b0, alu.a} + {1'b0, alu.b};
  assign low_w = {1'b0, alu.a[3:0]} + {1'b0, alu.b[3:0]};
  assign add_w = alu.valid && alu.op == OP_ADD && !bus.wr && !core_reset;
  // ****
  // Checks.
  // ****
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  chk_bank_map: assert property (bank_base == {3'b000, program_status_word[4:3], 3'b000})
    else $error("bank base does not follow bank select");
  chk_parity_acc: assert property (bus.wr && bus.addr == 8'hE0 && !sfr_map_select && !core_reset
    ##1 !bus.wr && !alu.valid && !core_reset |=> program_status_word[0] == ^$past(bus.wdata, 2))
    else $error("parity flag does not match accumulator");
  chk_add_carry: assert property (add_w |=> program_status_word[7:6] ==
    {$past(sum_w[8]), $past(low_w[4])}) else $error("carry flags wrong after add");
  chk_mc_period: assert property (machine_cycle |=>
    !machine_cycle [*8] ##1 !machine_cycle [*3] ##1 machine_cycle) else $error("cycle period wrong");
  chk_reset_rise: assert property ($rose(core_reset) |-> $past(machine_cycle)
    && $past(reset_pin) && $past(reset_pin, 13)) else $error("internal reset rose too early");
  chk_reset_fall: assert property (machine_cycle && !reset_pin |=> !core_reset)
    else $error("internal reset outlived the pin");
  chk_reset_clears: assert property (core_reset |=> program_status_word[7:1] == 7'h00)
    else $error("status word not cleared by reset");
  chk_map_kept: assert property (!(bus.wr && bus.addr == 8'hB1) && !core_reset
    |=> $stable(sfr_map_select)) else $error("map select changed on its own");
  chk_psw_read: assert property (bus.rd && bus.addr == 8'hD0 && !sfr_map_select && !core_reset
    |=> rdata == $past(program_status_word)) else $error("status word read wrong");
  cover property ($rose(core_reset));
  cover property (add_w);
  cover property (bus.wr && bus.addr == 8'hB1 && bus.wdata[4]);
endmodule : status_word_checker
bind cpu_status_word_and_reset status_word_checker status_word_checker_i (.ref_clk(ref_clk),
  .resetn(resetn), .reset_pin(reset_pin), .bus(bus), .alu(alu), .rdata(rdata),
  .program_status_word(program_status_word), .bank_base(bank_base),
  .sfr_map_select(sfr_map_select), .core_reset(core_reset), .machine_cycle(machine_cycle));
`default_nettype wire

// >>> cpu_status_word_and_reset_bench.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_status_word_and_reset_bench;
  import psw_pkg::*;
  logic       ref_clk = 1'b0;
  logic       resetn = 1'b0;
  logic       reset_pin = 1'b0;
  sfr_bus_t   bus = '0;
  alu_req_t   alu = '0;
  logic [7:0] rdata, program_status_word, bank_base;
  logic       sfr_map_select, core_reset, machine_cycle, seen;
  int         n_fail = 0;
  int         n_compared = 0;
  always #12.5 ref_clk = ~ref_clk;
  cpu_status_word_and_reset cpu_status_word_and_reset_i (.ref_clk(ref_clk), .resetn(resetn),
    .reset_pin(reset_pin), .bus(bus), .alu(alu), .rdata(rdata),
    .program_status_word(program_status_word), .bank_base(bank_base),
    .sfr_map_select(sfr_map_select), .core_reset(core_reset), .machine_cycle(machine_cycle));
  // ****
  // Access tasks.
  // ****
  task automatic check(input logic [7:0] got, exp, mask);
    n_compared++;
    if ((got & mask) !== (exp & mask)) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic access(input logic w, input logic [7:0] a, d);
    @(posedge ref_clk);
    bus <= '{a, d, w, !w};
    @(posedge ref_clk);
    bus <= '0;
    #1;
  endtask : access
  task automatic rd(input logic [7:0] a, exp);
    access(1'b0, a, 8'h00);
    check(rdata, exp, 8'hFF);
  endtask : rd
  task automatic step(input alu_op_t op, input logic [7:0] a, b, m, exp);
    @(posedge ref_clk);
    alu <= '{1'b1, op, a, b};
    @(posedge ref_clk);
    alu <= '0;
    access(1'b0, 8'hD0, 8'h00);
    check(rdata, exp, m);
  endtask : step
  task automatic pin_window(input int n);
    @(posedge ref_clk);
    reset_pin <= 1'b1;
    seen = 1'b0;
    repeat (n) @(negedge ref_clk) seen |= core_reset;
  endtask : pin_window
  task automatic report_and_stop;
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_fail++;
    report_and_stop();
  end
  // ****
  // Tests.
  // ****
  initial begin
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(8'hD0, 8'h00);
    for (int i = 0; i < 4; i++) begin
      access(1'b1, 8'hD0, 8'(i * 8));
      check(bank_base, 8'(i * 8), 8'hFF);
      rd(8'hD0, 8'(i * 8));
    end
    access(1'b1, 8'hE0, 8'h07);
    rd(8'hD0, 8'h19);
    access(1'b1, 8'hD0, 8'h22);
    rd(8'hD0, 8'h23);
    step(OP_ADD, 8'hFF, 8'h01, 8'hFF, 8'hE2);
    step(OP_ADD, 8'h7F, 8'h01, 8'hFF, 8'h67);
    step(OP_SUBB, 8'h00, 8'h01, 8'hFF, 8'hE2);
    step(OP_ADDC, 8'h00, 8'h00, 8'hFF, 8'h23);
    step(OP_MUL, 8'h10, 8'h10, 8'h85, 8'h04);
    step(OP_DIV, 8'h09, 8'h00, 8'h04, 8'h04);
    step(OP_NONE, 8'h55, 8'hAA, 8'hFF, 8'h26);
    access(1'b1, 8'hB1, 8'h10);
    check({7'h00, sfr_map_select}, 8'h01, 8'hFF);
    rd(8'hD0, 8'h00);
    access(1'b1, 8'hFC, 8'h00);
    rd(8'hFC, 8'hA5);
    rd(8'hFD, 8'h5A);
    rd(8'hFE, 8'h3C);
    access(1'b1, 8'h88, 8'h5A);
    rd(8'h88, 8'h5A);
    rd(8'hB1, 8'h10);
    access(1'b1, 8'hB1, 8'h00);
    rd(8'hFC, 8'h00);
    rd(8'h88, 8'h00);
    rd(8'h90, 8'h00);
    // A window of twelve clocks holds exactly one sample, so no reset may follow.
    pin_window(12);
    @(posedge ref_clk);
    reset_pin <= 1'b0;
    repeat (30) @(negedge ref_clk) seen |= core_reset;
    check({7'h00, seen}, 8'h00, 8'hFF);
    access(1'b1, 8'hB1, 8'h10);
    pin_window(36);
    check({7'h00, seen & core_reset}, 8'h01, 8'hFF);
    @(posedge ref_clk);
    reset_pin <= 1'b0;
    repeat (26) @(posedge ref_clk);
    #1;
    check({7'h00, core_reset, sfr_map_select}, 8'h00, 8'hFF);
    rd(8'hD0, 8'h00);
    report_and_stop();
  end
endmodule : cpu_status_word_and_reset_bench
`default_nettype wire
